// ==== hw/i2c_client.sv ====
// Two-wire client command handling and status flags with APB registers
//
// Design decision made here: the APB register port.
module i2c_client
   import i2c_client_pkg::*;
(
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        srst_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Bus pins
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe_out,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_out,
   // Interrupts
   output logic             data_irq_out,
   output logic             addr_irq_out,
   output logic             irq_out
);

   // ==========================================================================
   // Pin synchronisers
   logic [SYNC_STAGES-1:0] scl_sync_ff;
   logic [SYNC_STAGES-1:0] sda_sync_ff;
   logic                   scl_ff;
   logic                   sda_ff;
   logic                   scl_prev_ff;
   logic                   sda_prev_ff;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         scl_sync_ff <= '1;
         sda_sync_ff <= '1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[SYNC_STAGES-2:0], scl_in};
         sda_sync_ff <= {sda_sync_ff[SYNC_STAGES-2:0], sda_in};
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         scl_ff      <= 1'b1;
         sda_ff      <= 1'b1;
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         if (scl_sync_ff[1] == scl_sync_ff[2]) begin
            scl_ff <= scl_sync_ff[2];
         end
         if (sda_sync_ff[1] == sda_sync_ff[2]) begin
            sda_ff <= sda_sync_ff[2];
         end
         scl_prev_ff <= scl_ff;
         sda_prev_ff <= sda_ff;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_evt;
   logic stop_evt;
   assign scl_rise  = scl_ff & ~scl_prev_ff;
   assign scl_fall  = ~scl_ff & scl_prev_ff;
   assign start_evt = scl_ff & scl_prev_ff & sda_prev_ff & ~sda_ff;
   assign stop_evt  = scl_ff & scl_prev_ff & ~sda_prev_ff & sda_ff;

   // ==========================================================================
   // APB decode, one wait state
   logic       pready_ff;
   logic       apb_done;
   logic       wr_done;
   logic       rd_done;
   logic [7:0] reg_idx;
   logic       mapped;

   assign reg_idx  = {2'h0, paddr_in[7:2]};
   assign apb_done = psel_in & penable_in & pready_ff;
   assign wr_done  = apb_done & pwrite_in;
   assign rd_done  = apb_done & ~pwrite_in;
   assign mapped   = (paddr_in[1:0] == 2'h0) &&
                     (reg_idx inside {CTRL_A_IDX, CTRL_B_IDX, STATUS_IDX, ADDR_IDX,
                                      DATA_IDX, IRQ_STATUS_IDX, IRQ_MASK_IDX});

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= psel_in & penable_in & ~pready_ff;
      end
   end

   assign pready_out = pready_ff;

   // ==========================================================================
   // Software registers
   logic [7:0]       ctrl_a_ff;
   logic [1:0]       cmd_ff;
   logic             acknowledge_action_bit_ff;
   logic [7:0]       addr_ff;
   logic [7:0]       data_ff;
   irq_type          irq_mask_ff;
   irq_type          irq_stat_ff;
   status_type       st_ff;
   logic             cmd_wr;
   logic             data_acc;
   logic             flag_clr;

   assign cmd_wr   = wr_done && reg_idx == CTRL_B_IDX;
   assign data_acc = apb_done && reg_idx == DATA_IDX;
   assign flag_clr = cmd_wr | data_acc;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ctrl_a_ff   <= REG_RESET;
         addr_ff     <= REG_RESET;
         irq_mask_ff <= '0;
      end else if (wr_done) begin
         if (reg_idx == CTRL_A_IDX) begin
            ctrl_a_ff <= pwdata_in[7:0];
         end
         if (reg_idx == ADDR_IDX) begin
            addr_ff <= pwdata_in[7:0];
         end
         if (reg_idx == IRQ_MASK_IDX) begin
            irq_mask_ff <= pwdata_in[3:0];
         end
      end
   end

   // Acknowledge bit stored at the same edge as the command
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         cmd_ff    <= NOACT_CMD;
         acknowledge_action_bit_ff <= 1'b0;
      end else if (cmd_wr) begin
         cmd_ff    <= pwdata_in[1:0];
         acknowledge_action_bit_ff <= pwdata_in[CTRL_B_ACK_POS];
      end
   end

   // ==========================================================================
   // Client state machine
   client_state_type state_ff;
   client_state_type nxt_state;
   logic [3:0]       cnt_ff;
   logic [7:0]       shift_ff;
   logic             fin_ff;
   logic             cause_data_ff;
   logic             set_dif;
   logic             set_address_stop_flag_adr;
   logic             set_address_stop_flag_stop;
   logic             set_collision_flag;
   logic             set_bus_error_flag;
   logic             released;
   logic             enabled;
   logic             addr_match;

   assign enabled    = ctrl_a_ff[CTRL_A_ENABLE_POS];
   assign released   = state_ff == st_hold && !st_ff.data_done_flag && !st_ff.address_stop_flag;
   assign addr_match = shift_ff[7:1] == addr_ff[7:1];

   always_comb begin
      nxt_state     = state_ff;
      set_dif       = 1'b0;
      set_address_stop_flag_adr  = 1'b0;
      set_address_stop_flag_stop = 1'b0;
      set_collision_flag      = 1'b0;
      set_bus_error_flag    = 1'b0;
      if (!enabled) begin
         nxt_state = st_idle;
      end else if (start_evt) begin
         nxt_state = st_addr;
      end else if (stop_evt && state_ff != st_idle) begin
         nxt_state     = st_idle;
         set_address_stop_flag_stop = 1'b1;
         set_bus_error_flag    = state_ff == st_addr && cnt_ff == 4'h0;
      end else begin
         unique case (state_ff)
            st_idle, st_wait: begin
               nxt_state = state_ff;
            end
            st_addr: begin
               if (scl_fall && cnt_ff == BYTE_BITS) begin
                  nxt_state    = addr_match ? st_hold : st_wait;
                  set_address_stop_flag_adr = addr_match;
               end
            end
            st_hold: begin
               if (released) begin
                  if (cmd_ff == COMPLETE_TRANSACTION_CMD) begin
                     nxt_state = st_ff.dir ? st_wait : st_ack;
                  end else if (cause_data_ff && st_ff.dir) begin
                     nxt_state = st_tx;
                  end else begin
                     nxt_state = st_ack;
                  end
               end
            end
            st_ack: begin
               if (scl_fall) begin
                  if (fin_ff || acknowledge_action_bit_ff) begin
                     nxt_state = st_wait;
                  end else begin
                     nxt_state = st_ff.dir ? st_tx : st_rx;
                  end
               end
            end
            st_rx: begin
               if (scl_fall && cnt_ff == BYTE_BITS) begin
                  nxt_state = st_hold;
                  set_dif   = 1'b1;
               end
            end
            st_tx: begin
               set_collision_flag = scl_rise && shift_ff[7] && !sda_ff;
               if (scl_fall && cnt_ff == BYTE_BITS) begin
                  nxt_state = st_received_ack_bit;
               end
            end
            st_received_ack_bit: begin
               if (scl_fall) begin
                  nxt_state = st_hold;
                  set_dif   = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state_ff      <= st_idle;
         cnt_ff        <= 4'h0;
         shift_ff      <= 8'h00;
         fin_ff        <= 1'b0;
         cause_data_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (nxt_state == st_tx && state_ff != st_tx) begin
            shift_ff <= data_ff;
            cnt_ff   <= 4'h0;
         end else if (nxt_state != state_ff) begin
            cnt_ff <= 4'h0;
         end else if (state_ff == st_tx && scl_rise) begin
            cnt_ff <= cnt_ff + 4'h1;
         end else if (state_ff == st_tx && scl_fall) begin
            shift_ff <= {shift_ff[6:0], 1'b0};
         end else if ((state_ff == st_addr || state_ff == st_rx) && scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_ff};
            cnt_ff   <= cnt_ff + 4'h1;
         end
         if (state_ff == st_hold && released) begin
            fin_ff <= cmd_ff == COMPLETE_TRANSACTION_CMD;
         end
         if (set_dif) begin
            cause_data_ff <= 1'b1;
         end else if (set_address_stop_flag_adr) begin
            cause_data_ff <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Data register: software access or received byte
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         data_ff <= REG_RESET;
      end else if (state_ff == st_rx && set_dif) begin
         data_ff <= shift_ff;
      end else if (wr_done && reg_idx == DATA_IDX) begin
         data_ff <= pwdata_in[7:0];
      end
   end

   // ==========================================================================
   // Status flags, set wins over clear
   logic sw_w1c;
   assign sw_w1c = wr_done && reg_idx == STATUS_IDX;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         st_ff <= '0;
      end else begin
         if (set_dif) begin
            st_ff.data_done_flag <= 1'b1;
         end else if (flag_clr || (sw_w1c && pwdata_in[STATUS_DIF_POS])) begin
            st_ff.data_done_flag <= 1'b0;
         end
         if (set_address_stop_flag_adr || set_address_stop_flag_stop) begin
            st_ff.address_stop_flag <= 1'b1;
            st_ff.ap   <= set_address_stop_flag_adr;
         end else if (flag_clr || (sw_w1c && pwdata_in[STATUS_ADDRESS_STOP_FLAG_POS])) begin
            st_ff.address_stop_flag <= 1'b0;
         end
         if (set_collision_flag) begin
            st_ff.collision_flag <= 1'b1;
         end else if (start_evt || (sw_w1c && pwdata_in[STATUS_COLLISION_FLAG_POS])) begin
            st_ff.collision_flag <= 1'b0;
         end
         if (set_bus_error_flag) begin
            st_ff.bus_error_flag <= 1'b1;
         end else if (sw_w1c && pwdata_in[STATUS_BUS_ERROR_FLAG_POS]) begin
            st_ff.bus_error_flag <= 1'b0;
         end
         if (set_address_stop_flag_adr) begin
            st_ff.dir <= shift_ff[0];
         end
         if (state_ff == st_received_ack_bit && scl_rise) begin
            st_ff.received_ack_bit <= sda_ff;
         end
         st_ff.hold <= nxt_state == st_hold && (set_dif || set_address_stop_flag_adr ||
                       st_ff.data_done_flag || st_ff.address_stop_flag);
      end
   end

   // ==========================================================================
   // Pin drive
   always_comb begin
      scl_out    = 1'b0;
      sda_out    = 1'b0;
      scl_oe_out = st_ff.hold;
      unique case (state_ff)
         st_ack:   sda_oe_out = !acknowledge_action_bit_ff;
         st_tx:    sda_oe_out = !shift_ff[7];
         default:  sda_oe_out = 1'b0;
      endcase
   end

   // ==========================================================================
   // Interrupts and read back
   irq_type irq_evt;
   logic    irq_rd;
   assign irq_evt = {set_bus_error_flag, set_collision_flag, set_address_stop_flag_adr | set_address_stop_flag_stop, set_dif};
   assign irq_rd  = rd_done && reg_idx == IRQ_STATUS_IDX;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         irq_stat_ff <= '0;
      end else begin
         irq_stat_ff <= irq_evt | (irq_rd ? irq_type'(4'h0) : irq_stat_ff);
      end
   end

   assign data_irq_out = st_ff.data_done_flag & ctrl_a_ff[CTRL_A_DATA_IRQ_ENABLE_POS];
   assign addr_irq_out = st_ff.address_stop_flag & ctrl_a_ff[CTRL_A_ADDRESS_STOP_IRQ_ENABLE_POS];
   assign irq_out      = |(irq_stat_ff & irq_mask_ff);

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         prdata_out  <= 32'h0;
         pslverr_out <= 1'b0;
      end else if (psel_in && penable_in && !pready_ff) begin
         pslverr_out <= !mapped;
         unique case (reg_idx)
            CTRL_A_IDX:     prdata_out <= {24'h0, ctrl_a_ff};
            CTRL_B_IDX:     prdata_out <= {29'h0, acknowledge_action_bit_ff, cmd_ff};
            STATUS_IDX:     prdata_out <= {24'h0, st_ff};
            ADDR_IDX:       prdata_out <= {24'h0, addr_ff};
            DATA_IDX:       prdata_out <= {24'h0, data_ff};
            IRQ_STATUS_IDX: prdata_out <= {28'h0, irq_stat_ff};
            IRQ_MASK_IDX:   prdata_out <= {28'h0, irq_mask_ff};
            default:        prdata_out <= 32'h0;
         endcase
      end
   end

   // ==========================================================================
   // Assertions
   sequence release_s;
      state_ff == st_hold && !st_ff.data_done_flag && !st_ff.address_stop_flag;
   endsequence

   sequence comp_write_s;
      cmd_ff == COMPLETE_TRANSACTION_CMD && !st_ff.dir && enabled && !start_evt && !stop_evt;
   endsequence

   comp_write_a: assert property (@(posedge clock_in) disable iff (srst_in)
      release_s ##0 comp_write_s |=> state_ff == st_ack ##0 fin_ff)
      else $error("complete on host write did not acknowledge");
   comp_read_a: assert property (@(posedge clock_in) disable iff (srst_in)
      release_s ##0 cmd_ff == COMPLETE_TRANSACTION_CMD && st_ff.dir && enabled
      && !start_evt && !stop_evt |=> state_ff == st_wait)
      else $error("complete on host read did not wait");
   ack_update_a: assert property (@(posedge clock_in) disable iff (srst_in)
      cmd_wr |=> acknowledge_action_bit_ff == $past(pwdata_in[CTRL_B_ACK_POS]))
      else $error("acknowledge bit not updated with command");
   dif_set_a: assert property (@(posedge clock_in) disable iff (srst_in)
      set_dif |=> st_ff.data_done_flag && st_ff.hold)
      else $error("data flag not set");
   data_irq_a: assert property (@(posedge clock_in) disable iff (srst_in)
      $rose(st_ff.data_done_flag) && ctrl_a_ff[CTRL_A_DATA_IRQ_ENABLE_POS] |-> data_irq_out)
      else $error("data interrupt missing");
   dif_clear_a: assert property (@(posedge clock_in) disable iff (srst_in)
      data_acc && !set_dif |=> !st_ff.data_done_flag)
      else $error("data flag not cleared by access");
   address_stop_flag_clear_a: assert property (@(posedge clock_in) disable iff (srst_in)
      cmd_wr && !set_address_stop_flag_adr && !set_address_stop_flag_stop |=> !st_ff.address_stop_flag)
      else $error("address flag not cleared by command");
   stretch_hold_a: assert property (@(posedge clock_in) disable iff (srst_in)
      set_address_stop_flag_adr |=> scl_oe_out ##1 (scl_oe_out || !st_ff.address_stop_flag))
      else $error("clock not held on address");
   collision_flag_start_a: assert property (@(posedge clock_in) disable iff (srst_in)
      start_evt && enabled |=> !st_ff.collision_flag)
      else $error("collision not cleared by start");
   stop_cause_a: assert property (@(posedge clock_in) disable iff (srst_in)
      set_address_stop_flag_stop |=> st_ff.address_stop_flag && !st_ff.ap)
      else $error("stop cause wrong");
   reset_zero_a: assert property (@(posedge clock_in)
      srst_in |=> st_ff == '0 && !irq_out && !data_irq_out)
      else $error("status not zero after reset");

endmodule : i2c_client

// ==== shared/i2c_client_pkg.sv ====
// Constants and types for the two-wire client command and status block
package i2c_client_pkg;

   // ==========================================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] CTRL_A_IDX     = 8'h08;
   localparam logic [7:0] CTRL_B_IDX     = 8'h09;
   localparam logic [7:0] STATUS_IDX     = 8'h0b;
   localparam logic [7:0] ADDR_IDX       = 8'h0c;
   localparam logic [7:0] DATA_IDX       = 8'h0d;
   localparam logic [7:0] IRQ_STATUS_IDX = 8'h10;
   localparam logic [7:0] IRQ_MASK_IDX   = 8'h11;

   // ==========================================================================
   // Field positions
   localparam int CTRL_A_ENABLE_POS = 0;
   localparam int CTRL_A_ADDRESS_STOP_IRQ_ENABLE_POS  = 6;
   localparam int CTRL_A_DATA_IRQ_ENABLE_POS   = 7;
   localparam int CTRL_B_ACK_POS    = 2;
   localparam int STATUS_DIF_POS    = 7;
   localparam int STATUS_ADDRESS_STOP_FLAG_POS   = 6;
   localparam int STATUS_COLLISION_FLAG_POS   = 3;
   localparam int STATUS_BUS_ERROR_FLAG_POS = 2;

   // ==========================================================================
   // Commands and reset values
   localparam logic [1:0] NOACT_CMD                = 2'h0;
   localparam logic [1:0] COMPLETE_TRANSACTION_CMD = 2'h2;
   localparam logic [1:0] RESPONSE_CMD             = 2'h3;
   localparam logic [7:0] REG_RESET                = 8'h00;
   localparam logic [3:0] BYTE_BITS                = 4'h8;
   localparam int         SYNC_STAGES              = 3;

   // ==========================================================================
   // Status register layout
   typedef struct packed {
      logic data_done_flag;
      logic address_stop_flag;
      logic hold;
      logic received_ack_bit;
      logic collision_flag;
      logic bus_error_flag;
      logic dir;
      logic ap;
   } status_type;

   // Sticky interrupt events
   typedef struct packed {
      logic bus_error_flag;
      logic collision_flag;
      logic address_stop_flag;
      logic data_done_flag;
   } irq_type;

   typedef enum logic [2:0] {
      st_idle, st_addr, st_hold, st_ack, st_rx, st_tx, st_received_ack_bit, st_wait
   } client_state_type;

endpackage : i2c_client_pkg

// ==== testbench/i2c_host_model.sv ====
// Behavioural two-wire bus host driving open-drain lines
module i2c_host_model (
   // Bus levels
   input  wire logic scl_in,
   input  wire logic sda_in,
   // Pull-down requests
   output logic      scl_low_out,
   output logic      sda_low_out
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      scl_low_out = 1'b0;
      sda_low_out = 1'b0;
   end

   // ==========================================================================
   // One bit, waits while the client stretches SCL
   task automatic bit_io(input logic b, output logic s);
      sda_low_out = !b;
      #10;
      scl_low_out = 1'b0;
      for (int n = 0; n < 20000 && scl_in !== 1'b1; n++) #8;
      #30;
      s = sda_in;
      scl_low_out = 1'b1;
      #40;
   endtask : bit_io

   // ==========================================================================
   // Start, Stop and whole bytes
   task automatic start_cond;
      sda_low_out = 1'b0;
      #20;
      scl_low_out = 1'b0;
      #20;
      sda_low_out = 1'b1;
      #40;
      scl_low_out = 1'b1;
      #20;
   endtask : start_cond

   task automatic stop_cond;
      sda_low_out = 1'b1;
      #20;
      scl_low_out = 1'b0;
      #40;
      sda_low_out = 1'b0;
      #40;
   endtask : stop_cond

   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, ack);
   endtask : send_byte

endmodule : i2c_host_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the two-wire client command and status block
module testbench
   import i2c_client_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================================
   // Signals
   logic        clock_in   = 1'b0;
   logic        srst_in    = 1'b1;
   logic        psel_in    = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in  = 1'b0;
   logic [7:0]  paddr_in   = 8'h00;
   logic [31:0] pwdata_in  = 32'h0;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic        scl_out;
   logic        scl_oe_out;
   logic        sda_out;
   logic        sda_oe_out;
   logic        data_irq_out;
   logic        addr_irq_out;
   logic        irq_out;
   logic        h_scl;
   logic        h_sda;
   wire logic   scl_bus;
   wire logic   sda_bus;
   logic [31:0] rd;
   logic        err;
   logic        ack;
   logic [6:0]  caddr;
   logic [7:0]  d1;
   logic [7:0]  d2;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cyc       = 0;

   assign scl_bus = !(h_scl | (scl_oe_out & !scl_out));
   assign sda_bus = !(h_sda | (sda_oe_out & !sda_out));

   always #4 clock_in = ~clock_in;

   i2c_client i_i2c_client (
      .clock_in(clock_in), .srst_in(srst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .scl_in(scl_bus), .scl_out(scl_out),
      .scl_oe_out(scl_oe_out), .sda_in(sda_bus), .sda_out(sda_out),
      .sda_oe_out(sda_oe_out), .data_irq_out(data_irq_out),
      .addr_irq_out(addr_irq_out), .irq_out(irq_out)
   );

   i2c_host_model i_i2c_host_model (
      .scl_in(scl_bus), .sda_in(sda_bus), .scl_low_out(h_scl), .sda_low_out(h_sda)
   );

   // ==========================================================================
   // Checking, bus cycles and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge clock_in);
      psel_in   <= 1'b1;
      pwrite_in <= w;
      paddr_in  <= {idx[5:0], 2'b00};
      pwdata_in <= wd;
      @(posedge clock_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clock_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      check(rd & m, exp);
   endtask : rchk

   task automatic wait_irq(input logic data_sel);
      for (int n = 0; n < 8000; n++) begin
         @(posedge clock_in);
         if ((data_sel ? data_irq_out : addr_irq_out) === 1'b1) break;
      end
   endtask : wait_irq

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : tally_and_finish

   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   // ==========================================================================
   // Tests
   initial begin
      void'($urandom(56));
      caddr = 7'($urandom_range(127, 1));
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      repeat (4) @(posedge clock_in);
      srst_in <= 1'b0;
      rchk(STATUS_IDX, 32'hffffffff, 32'h0);
      check(32'(irq_out | data_irq_out | addr_irq_out), 32'h0);
      apb(1'b0, 8'h3f, 32'h0);
      check(32'(err), 32'h1);
      apb(1'b1, ADDR_IDX, {24'h0, caddr, 1'b0});
      apb(1'b1, CTRL_A_IDX, 32'h000000c1);
      apb(1'b1, IRQ_MASK_IDX, 32'h0000000d);
      $display("test reset done");
      fork
         begin
            i_i2c_host_model.start_cond();
            i_i2c_host_model.send_byte({caddr, 1'b0}, ack);
            check(32'(ack), 32'h0);
         end
         begin
            wait_irq(1'b0);
            rchk(STATUS_IDX, 32'hef, 32'h61);
            check(32'(irq_out), 32'h0);
            apb(1'b1, IRQ_MASK_IDX, 32'h0000000f);
            @(posedge clock_in);
            check(32'(irq_out), 32'h1);
            apb(1'b1, CTRL_B_IDX, {30'h0, RESPONSE_CMD});
            rchk(STATUS_IDX, 32'he0, 32'h0);
         end
      join
      $display("test address done");
      fork
         begin
            i_i2c_host_model.send_byte(d1, ack);
            check(32'(ack), 32'h0);
         end
         begin
            wait_irq(1'b1);
            check(32'(addr_irq_out), 32'h0);
            rchk(STATUS_IDX, 32'he0, 32'ha0);
            rchk(DATA_IDX, 32'hff, {24'h0, d1});
            rchk(STATUS_IDX, 32'he0, 32'h0);
         end
      join
      fork
         begin
            i_i2c_host_model.send_byte(d2, ack);
            check(32'(ack), 32'h1);
         end
         begin
            wait_irq(1'b1);
            apb(1'b1, CTRL_B_IDX, 32'h00000006);
            rchk(STATUS_IDX, 32'he0, 32'h0);
         end
      join
      $display("test host write done");
      i_i2c_host_model.stop_cond();
      wait_irq(1'b0);
      rchk(STATUS_IDX, 32'hef, 32'h40);
      apb(1'b1, STATUS_IDX, 32'h0);
      rchk(STATUS_IDX, 32'hc0, 32'h40);
      apb(1'b1, STATUS_IDX, 32'hff);
      rchk(STATUS_IDX, 32'hef, 32'h0);
      rchk(IRQ_STATUS_IDX, 32'hf, 32'h3);
      rchk(IRQ_STATUS_IDX, 32'hf, 32'h0);
      @(posedge clock_in);
      check(32'(irq_out), 32'h0);
      $display("test stop and flags done");
      fork
         begin
            i_i2c_host_model.start_cond();
            i_i2c_host_model.send_byte({caddr, 1'b1}, ack);
            check(32'(ack), 32'h1);
         end
         begin
            wait_irq(1'b0);
            rchk(STATUS_IDX, 32'he3, 32'h63);
            apb(1'b1, CTRL_B_IDX, {30'h0, COMPLETE_TRANSACTION_CMD});
         end
      join
      i_i2c_host_model.stop_cond();
      wait_irq(1'b0);
      rchk(STATUS_IDX, 32'hc1, 32'h40);
      $display("test host read done");
      tally_and_finish();
   end

endmodule : testbench
